// ==== tms_modulator.sv ====
module tms_modulator (
	// clock and reset
	input  wire logic                  i_clk_sys,
	input  wire logic                  i_srst,
	// register bus
	input  wire tms_pkg::tms_ahb_req_t i_ahb,
	output tms_pkg::tms_ahb_rsp_t      o_ahb,
	// transmit fifo
	input  wire logic                  i_fifo_valid,
	input  wire logic [7:0]            i_fifo_byte,
	output logic                       o_fifo_ready,
	// synthesizer and amplifier
	output tms_pkg::tms_amp_t          o_amp,
	output logic [1:0]                 o_amp_bessel_cutoff,
	output logic                       o_smoothing_enable,
	// status and demodulator
	output logic [1:0]                 o_equalizer_control,
	output logic                       o_tx_active
);
	import tms_pkg::*;

	// ==========================================================
	// state
	typedef struct packed {
		tms_ahb_rsp_t     rsp;
		logic             dp_wr;
		logic [7:0]       dp_addr;
		logic [3:0]       modulation_type;
		logic [1:0]       src;
		logic [1:0]       equ;
		logic             interp_en;
		logic             smoothing_filter_enable;
		logic [1:0]       fir_mode;
		logic [1:0]       bessel;
		logic [2:0]       top;
		logic [2:0]       step_len;
		logic [1:0]       cmap;
		logic [15:0]      mant;
		logic [3:0]       expo;
		logic [11:0]      fdev;
		logic [7:0][7:0]  ptab;
		tms_run_t         run;
		logic [31:0]      acc;
		logic [15:0]      div_cnt;
		logic [2:0]       eighth_cnt;
		logic [2:0]       step_cnt;
		logic [2:0]       idx;
		logic [2:0]       prev;
		logic [6:0]       frac;
		logic [1:0]       sym;
		logic [7:0]       shreg;
		logic [3:0]       bits_left;
		logic [8:0]       pn9;
		logic [7:0]       hist;
		logic [3:0]       fir_cnt;
		tms_pp_t          pp;
		logic [7:0]       pol_dev;
		logic [7:0]       pol_pwr;
		logic             fifo_rd;
		tms_amp_t         amp;
	} tms_st_t;

	tms_st_t s;
	tms_st_t next_s;

	// ==========================================================
	// helpers
	function automatic logic is_ptab(input logic [7:0] a);
		return (a >= A_PTAB) && (a <= A_PTAB_LAST);
	endfunction

	function automatic logic [2:0] ptab_idx(input logic [7:0] a);
		logic [7:0] d;
		d = a - A_PTAB;
		return d[4:2];
	endfunction

	function automatic logic [3:0] pop8(input logic [7:0] v);
		logic [3:0] c;
		c = 4'h0;
		for (int k = 0; k < 8; k++) begin
			c = c + {3'h0, v[k]};
		end
		return c;
	endfunction

	function automatic logic [8:0] pn9_step(input logic [8:0] p);
		return {p[7:0], p[8] ^ p[4]};
	endfunction

	// blend from a toward b by f over two to the sh
	function automatic logic [6:0] lerp(input logic [6:0] a, input logic [6:0] b,
			input logic [6:0] f, input logic [2:0] sh);
		logic signed [8:0]  d;
		logic signed [16:0] p;
		logic signed [16:0] r;
		d = $signed({2'b00, b}) - $signed({2'b00, a});
		p = 17'(d) * $signed({10'h000, f});
		r = $signed({10'h000, a}) + (p >>> sh);
		return r[6:0];
	endfunction

	// RULE9 interpolation factor as a shift
	function automatic logic [2:0] interp_shift(input logic [3:0] e);
		logic [3:0] t;
		t = (EXP_KNEE + {1'b0, ISH_MAX}) - e;
		if (e < EXP_KNEE) begin
			return ISH_MAX;
		end else if (e < EXP_OFF) begin
			return t[2:0];
		end
		return 3'h0;
	endfunction

	// ==========================================================
	// next state
	always_comb begin
		logic        take_a;
		logic        take_f;
		logic        cmd_start;
		logic        cmd_abort;
		logic        exact;
		logic        eighth;
		logic        sym_tick;
		logic        itick;
		logic        four;
		logic        bitv;
		logic        polar;
		logic        fir_ramp;
		logic [2:0]  sh;
		logic [2:0]  len;
		logic [2:0]  tgt;
		logic [6:0]  e0;
		logic [6:0]  mx;
		logic [6:0]  lim;
		logic [6:0]  pw;
		logic [10:0] fprod;
		logic [19:0] third;
		logic [11:0] mag;
		logic [31:0] inc;
		logic [31:0] acc_new;
		logic [31:0] carries;
		logic [31:0] rd;
		logic signed [20:0] pprod;
		int          ibit;
		take_a    = 1'b0;
		take_f    = 1'b0;
		cmd_start = 1'b0;
		cmd_abort = 1'b0;
		exact     = 1'b0;
		eighth    = 1'b0;
		sym_tick  = 1'b0;
		itick     = 1'b0;
		four      = 1'b0;
		bitv      = 1'b0;
		polar     = 1'b0;
		fir_ramp  = 1'b0;
		sh        = 3'h0;
		len       = 3'h0;
		tgt       = 3'h0;
		e0        = 7'h00;
		mx        = 7'h00;
		lim       = 7'h00;
		pw        = 7'h00;
		fprod     = 11'h000;
		third     = 20'h0_0000;
		mag       = 12'h000;
		inc       = 32'h0000_0000;
		acc_new   = 32'h0000_0000;
		carries   = 32'h0000_0000;
		rd        = 32'h0000_0000;
		pprod     = 21'sh0_0000;
		ibit      = ITICK_BASE;
		next_s    = s;

		// ======================================================
		// bus data phase: writes land one cycle after the address
		if (s.dp_wr) begin
			unique case (s.dp_addr)
				A_MOD: begin
					next_s.modulation_type = i_ahb.hwdata[MT_LSB +: 4];
				end
				A_CFG: begin
					next_s.src       = i_ahb.hwdata[SRC_LSB +: 2];
					next_s.equ       = i_ahb.hwdata[EQU_LSB +: 2];
					next_s.interp_en = i_ahb.hwdata[INTERP_BIT];
					next_s.smoothing_filter_enable    = i_ahb.hwdata[SMOOTHING_FILTER_ENABLE_BIT];
					next_s.fir_mode  = i_ahb.hwdata[FIR_M_LSB +: 2];
					next_s.bessel    = i_ahb.hwdata[BES_LSB +: 2];
					next_s.top       = i_ahb.hwdata[TOP_LSB +: 3];
					next_s.step_len  = i_ahb.hwdata[STEP_LSB +: 3];
					next_s.cmap      = i_ahb.hwdata[CMAP_LSB +: 2];
				end
				A_RATE: begin
					next_s.mant = i_ahb.hwdata[MANT_LSB +: 16];
					next_s.expo = i_ahb.hwdata[EXP_LSB +: 4];
				end
				A_DEV: begin
					next_s.fdev = i_ahb.hwdata[FDEV_LSB +: 12];
				end
				A_CMD: begin
					cmd_start = i_ahb.hwdata[START_BIT];
					cmd_abort = i_ahb.hwdata[ABORT_BIT];
				end
				default: begin
					if (is_ptab(s.dp_addr)) begin
						next_s.ptab[ptab_idx(s.dp_addr)] = i_ahb.hwdata[7:0];
					end
				end
			endcase
		end

		// ======================================================
		// bus address phase; read mux sees this cycle's write
		take_a = i_ahb.hsel && i_ahb.hready && i_ahb.htrans[1];
		next_s.dp_wr   = take_a && i_ahb.hwrite;
		next_s.dp_addr = {i_ahb.haddr[7:2], 2'b00};
		unique case (next_s.dp_addr)
			A_MOD: rd[MT_LSB +: 4] = next_s.modulation_type;
			A_CFG: begin
				rd[SRC_LSB +: 2]   = next_s.src;
				rd[EQU_LSB +: 2]   = next_s.equ;
				rd[INTERP_BIT]     = next_s.interp_en;
				rd[SMOOTHING_FILTER_ENABLE_BIT]     = next_s.smoothing_filter_enable;
				rd[FIR_M_LSB +: 2] = next_s.fir_mode;
				rd[BES_LSB +: 2]   = next_s.bessel;
				rd[TOP_LSB +: 3]   = next_s.top;
				rd[STEP_LSB +: 3]  = next_s.step_len;
				rd[CMAP_LSB +: 2]  = next_s.cmap;
			end
			A_RATE: begin
				rd[MANT_LSB +: 16] = next_s.mant;
				rd[EXP_LSB +: 4]   = next_s.expo;
			end
			A_DEV: rd[FDEV_LSB +: 12] = next_s.fdev;
			A_STAT: begin
				rd[ST_RUN_BIT]      = (s.run == TS_RUN);
				rd[ST_IDX_LSB +: 3] = s.idx;
				rd[ST_PWR_LSB +: 7] = s.amp.power;
				rd[ST_SUP_BIT]      = s.smoothing_filter_enable && (s.fir_mode == FIR_RAMP);
			end
			default: begin
				if (is_ptab(next_s.dp_addr)) begin
					rd[7:0] = next_s.ptab[ptab_idx(next_s.dp_addr)];
				end
			end
		endcase
		next_s.rsp.hrdata    = (take_a && !i_ahb.hwrite) ? rd : 32'h0000_0000;
		next_s.rsp.hreadyout = 1'b1;
		next_s.rsp.hresp     = 1'b0;

		// ======================================================
		// symbol timing
		exact = (s.expo == EXP_EXACT);
		// RULE21 mantissa and exponent to phase step
		if (s.expo == 4'h0) begin
			inc = {15'h0000, s.mant, 1'b0};
		end else begin
			inc = (MANT_OFFSET + {16'h0000, s.mant}) << s.expo;
		end
		acc_new = s.acc + inc;
		carries = s.acc ^ inc ^ acc_new;
		sh      = interp_shift(s.expo);
		// RULE10 tick bit slides with the exponent
		if (s.expo >= EXP_KNEE && s.expo < EXP_OFF) begin
			ibit = ITICK_BASE + int'(s.expo - EXP_KNEE);
		end
		if (s.run == TS_RUN) begin
			// RULE22 fractional divider, or exact integer divider
			if (exact) begin
				eighth = (s.div_cnt <= 16'h0001);
				next_s.div_cnt = eighth ? s.mant : s.div_cnt - 16'h0001;
			end else begin
				eighth = carries[EIGHTH_BIT];
				next_s.acc = acc_new;
				itick = (sh != 3'h0) && carries[ibit];
			end
		end
		sym_tick = eighth && (s.eighth_cnt == 3'h7);
		if (eighth) begin
			next_s.eighth_cnt = s.eighth_cnt + 3'h1;
		end

		// ======================================================
		// bit source
		polar = (s.modulation_type == MT_POLAR);
		four  = (s.modulation_type == MT_4FSK) || (s.modulation_type == MT_4GFSK);
		if (sym_tick && !polar) begin
			// RULE20 pn9 runs until abort
			if (s.src == SRC_PN9) begin
				next_s.sym = four ? s.pn9[8:7] : {1'b0, s.pn9[8]};
				next_s.pn9 = four ? pn9_step(pn9_step(s.pn9)) : pn9_step(s.pn9);
			end else if (four && s.bits_left >= 4'h2) begin
				next_s.sym       = s.shreg[7:6];
				next_s.shreg     = {s.shreg[5:0], 2'b00};
				next_s.bits_left = s.bits_left - 4'h2;
			end else if (!four && s.bits_left != 4'h0) begin
				next_s.sym       = {1'b0, s.shreg[7]};
				next_s.shreg     = {s.shreg[6:0], 1'b0};
				next_s.bits_left = s.bits_left - 4'h1;
			end else begin
				// underrun sends zeros
				next_s.sym = 2'b00;
			end
		end

		// ======================================================
		// fifo intake
		take_f = s.fifo_rd && i_fifo_valid;
		if (take_f) begin
			if (!polar) begin
				next_s.shreg     = i_fifo_byte;
				next_s.bits_left = 4'h8;
			end else if (s.pp == PP_FIRST) begin
				next_s.pol_dev = i_fifo_byte;
				next_s.pp      = PP_SECOND;
			end else begin
				next_s.pol_pwr = i_fifo_byte;
				next_s.pp      = PP_READY;
			end
		end

		// ======================================================
		// amplitude sequencing
		e0   = s.ptab[0][6:0];
		mx   = s.ptab[s.top][6:0];
		// RULE4 any nonzero mapping inverts
		bitv = s.sym[0] ^ (s.cmap != 2'b00);
		// RULE14 filter ramping suppresses digital ramping
		fir_ramp = s.smoothing_filter_enable && (s.fir_mode == FIR_RAMP);
		len = (s.step_len == 3'h0) ? 3'h1 : s.step_len;
		tgt = bitv ? s.top : 3'h0;
		lim = 7'h01 << sh;
		if (eighth) begin
			next_s.hist = {s.hist[6:0], bitv};
			if (bitv && s.fir_cnt != FIR_FULL) begin
				next_s.fir_cnt = s.fir_cnt + 4'h1;
			end else if (!bitv && s.fir_cnt != 4'h0) begin
				next_s.fir_cnt = s.fir_cnt - 4'h1;
			end
			// RULE6 step length in eighths
			if (s.step_cnt + 3'h1 >= len) begin
				next_s.step_cnt = 3'h0;
				// RULE5 walk the table toward the target
				// RULE7 at the target the level holds
				if (s.idx != tgt && !fir_ramp) begin
					next_s.prev = s.idx;
					next_s.idx  = (s.idx < tgt) ? s.idx + 3'h1 : s.idx - 3'h1;
					next_s.frac = 7'h00;
				end
			end else begin
				next_s.step_cnt = s.step_cnt + 3'h1;
			end
		end
		if (itick && s.frac < lim) begin
			next_s.frac = s.frac + 7'h01;
		end

		// ======================================================
		// outputs to synthesizer and amplifier
		next_s.amp = '0;
		third = {8'h00, s.fdev} * {12'h000, THIRD_MUL};
		// RULE23 modulation code selection
		unique case (s.modulation_type)
			MT_2FSK, MT_2GFSK: begin
				next_s.amp.enable = 1'b1;
				next_s.amp.power  = mx;
				next_s.amp.dev    = (s.sym[0] ^ s.cmap[1]) ?
					$signed({4'h0, s.fdev}) : -$signed({4'h0, s.fdev});
			end
			MT_4FSK, MT_4GFSK: begin
				mag = (s.sym[0] ^ s.cmap[0]) ? s.fdev : third[19:8];
				next_s.amp.enable = 1'b1;
				next_s.amp.power  = mx;
				next_s.amp.dev    = (s.sym[1] ^ s.cmap[1]) ?
					$signed({4'h0, mag}) : -$signed({4'h0, mag});
			end
			MT_ASK: begin
				if (s.smoothing_filter_enable) begin
					// RULE11 three smoothing shapes
					if (s.fir_mode == FIR_FILT) begin
						fprod = {4'h0, mx} * {7'h00, pop8(s.hist)};
						pw    = fprod[9:3];
					end else if (fir_ramp) begin
						pw = lerp(e0, mx, {3'h0, s.fir_cnt}, FIR_SH);
					end else begin
						pw = bitv ? mx : e0;
					end
				end else if (e0 == 7'h00) begin
					// RULE2 on-off keying
					// RULE3 zero entry 0 selects on-off
					pw = bitv ? mx : 7'h00;
				end else if (s.interp_en && sh != 3'h0) begin
					// RULE8 linear blend between steps
					pw = lerp(s.ptab[s.prev][6:0], s.ptab[s.idx][6:0], s.frac, sh);
				end else begin
					pw = s.ptab[s.idx][6:0];
				end
				next_s.amp.power  = pw;
				next_s.amp.enable = (pw != 7'h00);
			end
			MT_POLAR: begin
				next_s.amp = s.amp;
				// RULE15 one pair per eighth symbol
				if (eighth && s.pp == PP_READY) begin
					// RULE16 signed sample scales deviation
					pprod = $signed({1'b0, s.fdev}) * $signed(s.pol_dev);
					next_s.amp.dev = 16'(pprod >>> POLAR_SH);
					// RULE17 power code as in the table
					next_s.amp.power  = s.pol_pwr[6:0];
					next_s.amp.enable = (s.pol_pwr[6:0] != 7'h00);
					next_s.pp = PP_FIRST;
				end
			end
			MT_CW: begin
				// RULE19 bare carrier until abort
				next_s.amp.enable = 1'b1;
				next_s.amp.power  = mx;
			end
			default: begin
				next_s.amp = '0;
			end
		endcase

		// ======================================================
		// run control
		// RULE18 only abort ends transmission
		if (cmd_abort) begin
			next_s.run = TS_IDLE;
		end else if (cmd_start && s.run == TS_IDLE) begin
			next_s.run        = TS_RUN;
			next_s.acc        = 32'h0000_0000;
			next_s.div_cnt    = s.mant;
			next_s.eighth_cnt = 3'h0;
			next_s.step_cnt   = 3'h0;
			next_s.idx        = 3'h0;
			next_s.prev       = 3'h0;
			next_s.frac       = 7'h00;
			next_s.sym        = 2'b00;
			next_s.bits_left  = 4'h0;
			next_s.pn9        = PN9_SEED;
			next_s.hist       = 8'h00;
			next_s.fir_cnt    = 4'h0;
			next_s.pp         = PP_FIRST;
		end
		if (next_s.run == TS_IDLE) begin
			next_s.amp = '0;
		end
		next_s.fifo_rd = (next_s.run == TS_RUN) && (polar ? (next_s.pp != PP_READY) :
			(s.src != SRC_PN9 && next_s.bits_left == 4'h0));
	end

	// ==========================================================
	// registers
	always_ff @(posedge i_clk_sys) begin
		// RULE24 reset idles with amplifier off
		if (i_srst) begin
			next_s_reset();
		end else begin
			s <= next_s;
		end
	end

	task automatic next_s_reset();
		s <= '0;
		s.rsp.hreadyout <= 1'b1;
		s.pn9           <= PN9_SEED;
	endtask

	// ==========================================================
	// ports
	assign o_ahb        = s.rsp;
	assign o_fifo_ready = s.fifo_rd;
	assign o_amp        = s.amp;
	// RULE13 cutoff choice left to software
	assign o_amp_bessel_cutoff = s.bessel;
	// RULE12 smoothing enable travels with entry 0
	assign o_smoothing_enable  = s.ptab[0][SMOOTH_BIT];
	// RULE1 equalizer mode for the demodulator
	assign o_equalizer_control = s.equ;
	assign o_tx_active         = (s.run == TS_RUN);

endmodule

// ==== tms_pkg.sv ====
// What this block does
// RULE1: equalizer control offers off, single-pass or dual-pass for 4-level FSK.
// RULE2: OOK sends '1' at top-index power, '0' with amplifier off.
// RULE3: power entry 0 zero means OOK, nonzero means amplitude keying.
// RULE4: nonzero constellation mapping inverts bit to power mapping.
// RULE5: ASK ramps up from entry 0 for '1', down again for '0'.
// RULE6: each ramp step lasts step-length eighths of a symbol.
// RULE7: repeated ones hold maximum; repeated zeros stay at minimum.
// RULE8: interpolation enable linearly blends successive table values.
// RULE9: interpolation factor 64, halved per exponent above 5, off at 11.
// RULE10: above exponent 5 update ticks fall 8 down to 4 clocks apart.
// RULE11: smoothing filter offers filter, ramp or switch configurations.
// RULE12: software sets the smoothing enable bit with the smoothing filter.
// RULE13: software matches the Bessel cutoff field to the data rate.
// RULE14: filter ramping and digital ramping are never active together.
// RULE15: polar mode takes byte pairs at eight times the symbol rate.
// RULE16: first polar byte is signed, scales deviation by value over 128.
// RULE17: second polar byte sets amplifier power in table encoding.
// RULE18: polar never stops itself; host feeds FIFO and aborts.
// RULE19: modulation code 0x77 gives unmodulated carrier until abort.
// RULE20: transmit source 3 feeds PN9 bits continuously until abort.
// RULE21: symbol rate from mantissa and exponent, exact divider at 15.
// RULE22: fractional divider below exponent 15, jitter-free integer at 15.
// RULE23: modulation codes select FSK, GFSK, ASK, polar and carrier.
// RULE24: all sequencing on the system clock, reset leaves amplifier off.
package tms_pkg;

	// ==========================================================
	// register map, byte addresses
	localparam logic [7:0] A_MOD       = 8'h00;
	localparam logic [7:0] A_CFG       = 8'h04;
	localparam logic [7:0] A_RATE      = 8'h08;
	localparam logic [7:0] A_DEV       = 8'h0C;
	localparam logic [7:0] A_PTAB      = 8'h10;
	localparam logic [7:0] A_PTAB_LAST = 8'h2C;
	localparam logic [7:0] A_CMD       = 8'h30;
	localparam logic [7:0] A_STAT      = 8'h34;

	// ==========================================================
	// field positions
	localparam int MT_LSB     = 4;
	localparam int SRC_LSB    = 0;
	localparam int EQU_LSB    = 2;
	localparam int INTERP_BIT = 4;
	localparam int SMOOTHING_FILTER_ENABLE_BIT = 5;
	localparam int FIR_M_LSB  = 6;
	localparam int BES_LSB    = 8;
	localparam int TOP_LSB    = 10;
	localparam int STEP_LSB   = 13;
	localparam int CMAP_LSB   = 16;
	localparam int MANT_LSB   = 0;
	localparam int EXP_LSB    = 16;
	localparam int FDEV_LSB   = 0;
	localparam int SMOOTH_BIT = 7;
	localparam int START_BIT  = 0;
	localparam int ABORT_BIT  = 1;
	localparam int ST_RUN_BIT = 0;
	localparam int ST_IDX_LSB = 1;
	localparam int ST_PWR_LSB = 4;
	localparam int ST_SUP_BIT = 11;

	// ==========================================================
	// encodings
	localparam logic [3:0] MT_2FSK  = 4'h0;
	localparam logic [3:0] MT_4FSK  = 4'h1;
	localparam logic [3:0] MT_2GFSK = 4'h2;
	localparam logic [3:0] MT_4GFSK = 4'h3;
	localparam logic [3:0] MT_ASK   = 4'h5;
	localparam logic [3:0] MT_POLAR = 4'h6;
	localparam logic [3:0] MT_CW    = 4'h7;
	localparam logic [1:0] SRC_PN9  = 2'h3;
	localparam logic [1:0] FIR_FILT = 2'h0;
	localparam logic [1:0] FIR_RAMP = 2'h1;

	// ==========================================================
	// timing and arithmetic constants
	localparam logic [3:0]  EXP_KNEE    = 4'h5;
	localparam logic [3:0]  EXP_OFF     = 4'hB;
	localparam logic [3:0]  EXP_EXACT   = 4'hF;
	localparam logic [2:0]  ISH_MAX     = 3'h6;
	localparam int          EIGHTH_BIT  = 30;
	localparam int          ITICK_BASE  = 24;
	localparam logic [31:0] MANT_OFFSET = 32'h0001_0000;
	localparam logic [8:0]  PN9_SEED    = 9'h1FF;
	localparam int          POLAR_SH    = 7;
	localparam logic [2:0]  FIR_SH      = 3'h3;
	localparam logic [3:0]  FIR_FULL    = 4'h8;
	localparam logic [7:0]  THIRD_MUL   = 8'h55;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} tms_ahb_req_t;

	typedef struct packed {
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
	} tms_ahb_rsp_t;

	typedef struct packed {
		logic               enable;
		logic [6:0]         power;
		logic signed [15:0] dev;
	} tms_amp_t;

	typedef enum logic {TS_IDLE, TS_RUN} tms_run_t;
	typedef enum logic [1:0] {PP_FIRST, PP_SECOND, PP_READY} tms_pp_t;

endpackage

// ==== tms_modulator_props.sv ====
module tms_modulator_props
	import tms_pkg::*;
(
	// watched ports
	input wire logic         i_clk_sys,
	input wire logic         i_srst,
	input wire tms_ahb_req_t i_ahb,
	input wire tms_ahb_rsp_t o_ahb,
	input wire logic         i_fifo_valid,
	input wire logic [7:0]   i_fifo_byte,
	input wire logic         o_fifo_ready,
	input wire tms_amp_t     o_amp,
	input wire logic [1:0]   o_amp_bessel_cutoff,
	input wire logic         o_smoothing_enable,
	input wire logic [1:0]   o_equalizer_control,
	input wire logic         o_tx_active
);
	// ==========
	// shadow of written registers
	logic        wr_ph;
	logic [7:0]  wr_a;
	logic [31:0] r_mod;
	logic [31:0] r_cfg;
	logic        r_smooth;
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			wr_ph    <= 1'b0;
			wr_a     <= 8'h00;
			r_mod    <= 32'h0000_0000;
			r_cfg    <= 32'h0000_0000;
			r_smooth <= 1'b0;
		end else begin
			wr_ph <= i_ahb.hsel && i_ahb.hready && i_ahb.htrans[1] && i_ahb.hwrite;
			wr_a  <= {i_ahb.haddr[7:2], 2'h0};
			if (wr_ph && wr_a == A_MOD)
				r_mod <= i_ahb.hwdata;
			if (wr_ph && wr_a == A_CFG)
				r_cfg <= i_ahb.hwdata;
			if (wr_ph && wr_a == A_PTAB)
				r_smooth <= i_ahb.hwdata[SMOOTH_BIT];
		end
	end
	// ==========
	// properties
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);
	chk_reset_quiet: assert property (
		$fell(i_srst) |-> !o_amp.enable && !o_tx_active && !o_fifo_ready)
		else $error("outputs on after reset");
	// amp output clears in the same cycle as the run flag; the check still waits two idle cycles
	chk_idle_amp_off: assert property (
		!o_tx_active [*2] |-> !o_amp.enable && o_amp.power == 7'h00)
		else $error("amplifier on while idle");
	chk_idle_no_take: assert property (
		!o_tx_active [*2] |-> !o_fifo_ready)
		else $error("fifo intake while idle");
	chk_smooth_follow: assert property (
		wr_ph && wr_a == A_PTAB |-> ##[1:2] o_smoothing_enable == r_smooth)
		else $error("smoothing enable stale");
	chk_bessel_follow: assert property (
		wr_ph && wr_a == A_CFG |-> ##[1:2] o_amp_bessel_cutoff == r_cfg[BES_LSB+:2])
		else $error("bessel cutoff stale");
	chk_equ_follow: assert property (
		wr_ph && wr_a == A_CFG |-> ##[1:2] o_equalizer_control == r_cfg[EQU_LSB+:2])
		else $error("equalizer control stale");
	chk_cw_steady: assert property (
		(o_tx_active && r_mod[MT_LSB+:4] == MT_CW) [*3] |-> o_amp.enable && o_amp.dev == 16'sh0000)
		else $error("carrier not steady");
	chk_pn9_no_take: assert property (
		(o_tx_active && r_cfg[1:0] == SRC_PN9 && r_mod[MT_LSB+:4] != MT_POLAR) [*2]
		|-> !o_fifo_ready)
		else $error("fifo intake with pn9 source");
endmodule

bind tms_modulator tms_modulator_props chk_u (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
	.i_ahb(i_ahb), .o_ahb(o_ahb), .i_fifo_valid(i_fifo_valid), .i_fifo_byte(i_fifo_byte),
	.o_fifo_ready(o_fifo_ready), .o_amp(o_amp), .o_amp_bessel_cutoff(o_amp_bessel_cutoff),
	.o_smoothing_enable(o_smoothing_enable), .o_equalizer_control(o_equalizer_control),
	.o_tx_active(o_tx_active));

// ==== tms_fifo_feed.sv ====
module tms_fifo_feed (
	// clock and handshake
	input  wire logic  i_clk_sys,
	input  wire logic  i_fifo_ready,
	input  wire logic  i_slow,
	output logic       o_fifo_valid,
	output logic [7:0] o_fifo_byte
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] q[$];
	int         took[$];
	logic [7:0] last = 8'h00;
	logic       tk;
	logic       offer;
	int         now = 0;
	initial {o_fifo_valid, o_fifo_byte} = 9'h000;
	// ==========
	// host side keeps samples coming
	always @(posedge i_clk_sys) begin
		tk = o_fifo_valid && i_fifo_ready;
		if (tk) begin
			last = q.pop_front();
			took.push_back(now);
		end
		// slow mode leaves a gap after every byte
		offer = q.size() > 0 && !(tk && i_slow);
		now <= now + 1;
		o_fifo_valid <= offer;
		// released line shows the inverse, not a stale byte
		o_fifo_byte <= offer ? q[0] : ~last;
	end
endmodule

// ==== tx_modulator_power_sequencer_tb.sv ====
module tx_modulator_power_sequencer_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import tms_pkg::*;
	// ==========
	// signals
	logic         i_clk_sys, i_srst, hsel, hwrite, slow;
	logic [31:0]  haddr, hwdata, rd;
	logic [1:0]   htrans, bes, equ;
	logic [2:0]   hsize;
	logic         fvalid, fready, smooth, txa;
	logic [7:0]   fbyte;
	tms_ahb_req_t req;
	tms_ahb_rsp_t rsp;
	tms_amp_t     amp;
	int           mismatches = 0;
	int           checks_done = 0;
	int           cyc = 0;
	assign req = '{hsel, haddr, htrans, hwrite, hsize, hwdata, rsp.hreadyout};
	tms_modulator dut_u (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_ahb(req), .o_ahb(rsp),
		.i_fifo_valid(fvalid), .i_fifo_byte(fbyte), .o_fifo_ready(fready), .o_amp(amp),
		.o_amp_bessel_cutoff(bes), .o_smoothing_enable(smooth), .o_equalizer_control(equ),
		.o_tx_active(txa));
	tms_fifo_feed feed_u (.i_clk_sys(i_clk_sys), .i_fifo_ready(fready), .i_slow(slow),
		.o_fifo_valid(fvalid), .o_fifo_byte(fbyte));
	initial begin
		i_clk_sys = 1'b0;
		forever #12.5 i_clk_sys = ~i_clk_sys;
	end
	// whole run needs about 3000 cycles
	always @(posedge i_clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	// ==========
	// shared tasks
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk_sys);
	endtask
	task automatic xf(input logic [7:0] a, input logic w, input logic [31:0] wd);
		hsel   <= 1'b1;
		haddr  <= {24'h00_0000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge i_clk_sys); while (rsp.hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge i_clk_sys); while (rsp.hreadyout !== 1'b1);
		rd = rsp.hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xf(a, 1'b1, d);
	endtask
	task automatic fill(input logic [7:0] b);
		feed_u.q.delete();
		repeat (24) feed_u.q.push_back(b);
	endtask
	task automatic go(input logic [31:0] mode, input int n);
		wr(A_MOD, mode);
		wr(A_CMD, 32'h0000_0001);
		tick(n);
	endtask
	task automatic stop();
		wr(A_CMD, 32'h0000_0002);
		tick(3);
		cmp("idle", 32'h0, {txa, amp.enable});
	endtask
	// ==========
	// scenarios
	task automatic t_fields();
		xf(A_RATE, 1'b0, 32'h0);
		cmp("rate", 32'h0, rd);
		xf(8'h3C, 1'b0, 32'h0);
		cmp("unmapped", 32'h0, rd);
		for (int i = 0; i < 4; i++) begin
			wr(A_CFG, (32'(i) << BES_LSB) | (32'(i) << EQU_LSB));
			tick(2);
			cmp("equ", 32'(i), 32'(equ));
			cmp("bessel", 32'(i), 32'(bes));
		end
		wr(A_CFG, 32'h0000_0060);
		xf(A_STAT, 1'b0, 32'h0);
		cmp("ramp suppress", 32'h800, rd & 32'h800);
		wr(A_PTAB, 32'h0000_0080);
		tick(2);
		cmp("smooth", 32'h1, 32'(smooth));
	endtask
	task automatic t_fsk();
		wr(A_DEV, 32'h0000_0100);
		wr(A_RATE, 32'h000F_0004);
		wr(A_CFG, 32'h0000_0000);
		for (int m = 0; m < 4; m++) begin
			fill(8'hFF);
			go(32'(m) << MT_LSB, 120);
			cmp("fsk dev", 32'h0000_0100, 32'(amp.dev));
			stop();
		end
		fill(8'h00);
		go(32'h0000_0077, 60);
		cmp("cw", 32'h1_0000, {amp.enable, amp.dev});
		stop();
	endtask
	task automatic t_ook();
		wr(A_PTAB, 32'h0000_0000);
		wr(A_PTAB + 8'h04, 32'h0000_0030);
		for (int k = 0; k < 3; k++) begin
			wr(A_CFG, (k == 2) ? 32'h0001_0400 : 32'h0000_0400);
			fill((k == 1) ? 8'h00 : 8'hFF);
			go(32'h0000_0050, 150);
			cmp("ook", (k == 0) ? 32'hB0 : 32'h0, {amp.enable, amp.power & {7{amp.enable}}});
			stop();
		end
	endtask
	task automatic t_ask();
		int n10 = 0;
		int n20 = 0;
		wr(A_PTAB, 32'h0000_0005);
		wr(A_PTAB + 8'h04, 32'h0000_0010);
		wr(A_PTAB + 8'h08, 32'h0000_0020);
		wr(A_PTAB + 8'h0C, 32'h0000_0030);
		wr(A_CFG, 32'h0000_4C00);
		fill(8'hFF);
		go(32'h0000_0050, 0);
		repeat (200) begin
			@(posedge i_clk_sys);
			n10 += int'(amp.power === 7'h10);
			n20 += int'(amp.power === 7'h20);
		end
		cmp("step a", 32'd8, n10);
		cmp("step b", 32'd8, n20);
		cmp("top", 32'h30, 32'(amp.power));
		stop();
		fill(8'h00);
		go(32'h0000_0050, 200);
		cmp("floor", 32'h85, {amp.enable, amp.power});
		stop();
	endtask
	task automatic t_polar();
		wr(A_RATE, 32'h000F_0014);
		slow <= 1'b1;
		feed_u.q.delete();
		feed_u.took.delete();
		repeat (4) feed_u.q = {feed_u.q, 8'h40, 8'h22, 8'hC0, 8'h33};
		go(32'h0000_0060, 0);
		for (int k = 0; k < 60 && amp.power !== 7'h22; k++) @(posedge i_clk_sys);
		cmp("pol a", 32'h80, 32'(amp.dev));
		for (int k = 0; k < 60 && amp.power !== 7'h33; k++) @(posedge i_clk_sys);
		cmp("pol b", 32'hFFFF_FF80, 32'(amp.dev));
		tick(300);
		cmp("pol gap", 32'd20, feed_u.took[6] - feed_u.took[4]);
		cmp("pol run", 32'h1, 32'(txa));
		stop();
		slow <= 1'b0;
	endtask
	task automatic t_pn9();
		int np = 0;
		int nn = 0;
		wr(A_RATE, 32'h000F_0004);
		wr(A_CFG, 32'h0000_0003);
		feed_u.q.delete();
		go(32'h0000_0000, 0);
		repeat (800) begin
			@(posedge i_clk_sys);
			np += int'(amp.dev > 0);
			nn += int'(amp.dev < 0);
		end
		cmp("pn9", 32'h3, {np > 0, nn > 0});
		stop();
	endtask
	initial begin
		{hsel, hwrite, slow, htrans, haddr, hwdata} = '0;
		hsize  = 3'h2;
		i_srst = 1'b1;
		tick(3);
		i_srst <= 1'b0;
		t_fields();
		t_fsk();
		t_ook();
		t_ask();
		t_polar();
		t_pn9();
		tally_and_finish();
	end
endmodule
